// ### rtl/dspt_pkg.sv
// constants and types for the dual-slope pwm timer
//==========================================================
package dspt_pkg;

  //==========================================================
  // register map
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CMPA = 4'h1;
  localparam logic [3:0] ADDR_CMPB = 4'h2;
  localparam logic [3:0] ADDR_CAPTOP = 4'h3;
  localparam logic [3:0] ADDR_COUNT = 4'h4;
  localparam logic [3:0] ADDR_FLAGS = 4'h5;

  //==========================================================
  // flag bit positions
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CAP = 1;
  localparam int FLAG_CMPA = 2;
  localparam int FLAG_CMPB = 3;

  //==========================================================
  // waveform mode codes
  localparam logic [3:0] WM_PC_8 = 4'h1;
  localparam logic [3:0] WM_PC_9 = 4'h2;
  localparam logic [3:0] WM_PC_10 = 4'h3;
  localparam logic [3:0] WM_PFC_CAP = 4'h8;
  localparam logic [3:0] WM_PFC_CMPA = 4'h9;
  localparam logic [3:0] WM_PC_CAP = 4'ha;
  localparam logic [3:0] WM_PC_CMPA = 4'hb;

  //==========================================================
  // output mode field codes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_NONINV = 2'h2;
  localparam logic [1:0] COM_INV = 2'h3;

  //==========================================================
  // count limits
  localparam logic [15:0] COUNT_FLOOR = 16'h0000;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [15:0] TOP_MIN = 16'h0003;

  //==========================================================
  // prescale selects and divider end counts
  localparam logic [2:0] PS_STOP = 3'h0;
  localparam logic [2:0] PS_1 = 3'h1;
  localparam logic [2:0] PS_8 = 3'h2;
  localparam logic [2:0] PS_64 = 3'h3;
  localparam logic [2:0] PS_256 = 3'h4;
  localparam logic [2:0] PS_1024 = 3'h5;
  localparam logic [9:0] DIV_END_1 = 10'h000;
  localparam logic [9:0] DIV_END_8 = 10'h007;
  localparam logic [9:0] DIV_END_64 = 10'h03f;
  localparam logic [9:0] DIV_END_256 = 10'h0ff;
  localparam logic [9:0] DIV_END_1024 = 10'h3ff;

  //==========================================================
  // reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] VALUE_RESET = 16'h0000;

  //==========================================================
  // types
  typedef enum logic {DSPT_UP, DSPT_DOWN} dspt_dir_t;

  typedef struct packed {
    logic [2:0] rsvd;
    logic dir_b;
    logic dir_a;
    logic [2:0] ps_sel;
    logic [1:0] com_b;
    logic [1:0] com_a;
    logic [3:0] wave;
  } dspt_ctrl_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } dspt_bus_t;

  typedef struct packed {
    dspt_ctrl_t ctrl;
    logic [1:0][15:0] cmp_buf;
    logic [1:0][15:0] cmp;
    logic [15:0] cap_top;
    logic [15:0] cnt;
    dspt_dir_t dir;
    logic [3:0] flags;
    logic [1:0] wave;
    logic [1:0] oe;
    logic [15:0] rdata;
  } dspt_state_t;

  typedef struct packed {
    logic [9:0] div;
    logic tick;
  } dspt_ps_state_t;

endpackage

// ### rtl/dspt_prescale.sv
// timer tick divider from the system clock
module dspt_prescale (
  input wire logic clk,
  input wire logic srst,
  input wire logic [2:0] sel,
  output logic tick
);

  dspt_pkg::dspt_ps_state_t st_r;
  dspt_pkg::dspt_ps_state_t st_nxt;
  logic [9:0] div_end;

  //==========================================================
  // end count per select
  always_comb
  begin
    case (sel)
      dspt_pkg::PS_1: div_end = dspt_pkg::DIV_END_1;
      dspt_pkg::PS_8: div_end = dspt_pkg::DIV_END_8;
      dspt_pkg::PS_64: div_end = dspt_pkg::DIV_END_64;
      dspt_pkg::PS_256: div_end = dspt_pkg::DIV_END_256;
      dspt_pkg::PS_1024: div_end = dspt_pkg::DIV_END_1024;
      default: div_end = dspt_pkg::DIV_END_1;
    endcase
  end

  //==========================================================
  // divider step, one-cycle tick at wrap
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (sel == dspt_pkg::PS_STOP || sel > dspt_pkg::PS_1024)
    begin
      st_nxt.div = 10'h000;
    end
    else if (st_r.div >= div_end)
    begin
      st_nxt.div = 10'h000;
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.div = 10'(st_r.div + 10'h001);
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule // dspt_prescale

// ### rtl/dspt_timer.sv
// dual-slope pwm timer with register port and two compare pins
//
// Chosen here: the placing of the registers and the plain strobed port.
module dspt_timer (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  output logic OC_A,
  output logic OC_A_OE,
  output logic OC_B,
  output logic OC_B_OE
);

  //==========================================================
  // declarations
  dspt_pkg::dspt_state_t st_r;
  dspt_pkg::dspt_state_t st_nxt;
  dspt_pkg::dspt_bus_t bus;
  logic tick;
  logic [15:0] top;
  logic [15:0] wmask;
  logic is_pc;
  logic is_pfc;
  logic run;
  logic cap_top_sel;
  logic cmpa_top_sel;
  logic step;
  logic at_top;
  logic at_floor;
  logic [1:0] match;
  logic [1:0] wave_nxt;
  logic [1:0] connected;
  logic [1:0] dir_bits;
  logic [1:0][1:0] com;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;

  // bundle the register port
  assign bus.addr = ADDR;
  assign bus.wdata = WDATA;
  assign bus.wr = WR;
  assign bus.rd = RD;

  //==========================================================
  // timer tick source
  dspt_prescale u_prescale (
    .clk(CLK_SYS),
    .srst(SRST),
    .sel(st_r.ctrl.ps_sel),
    .tick(tick)
  );

  //==========================================================
  // mode decode: family, top source, write mask
  always_comb
  begin
    is_pc = 1'b0;
    is_pfc = 1'b0;
    cap_top_sel = 1'b0;
    cmpa_top_sel = 1'b0;
    top = st_r.cap_top;
    wmask = 16'hffff;
    case (st_r.ctrl.wave)
      dspt_pkg::WM_PC_8:
      begin
        is_pc = 1'b1;
        top = dspt_pkg::TOP_8BIT;
        wmask = dspt_pkg::TOP_8BIT;
      end
      dspt_pkg::WM_PC_9:
      begin
        is_pc = 1'b1;
        top = dspt_pkg::TOP_9BIT;
        wmask = dspt_pkg::TOP_9BIT;
      end
      dspt_pkg::WM_PC_10:
      begin
        is_pc = 1'b1;
        top = dspt_pkg::TOP_10BIT;
        wmask = dspt_pkg::TOP_10BIT;
      end
      dspt_pkg::WM_PC_CAP:
      begin
        is_pc = 1'b1;
        cap_top_sel = 1'b1;
        top = st_r.cap_top;
      end
      dspt_pkg::WM_PC_CMPA:
      begin
        is_pc = 1'b1;
        cmpa_top_sel = 1'b1;
        top = st_r.cmp[0];
      end
      dspt_pkg::WM_PFC_CAP:
      begin
        is_pfc = 1'b1;
        cap_top_sel = 1'b1;
        top = st_r.cap_top;
      end
      dspt_pkg::WM_PFC_CMPA:
      begin
        is_pfc = 1'b1;
        cmpa_top_sel = 1'b1;
        top = st_r.cmp[0];
      end
      default:
      begin
        is_pc = 1'b0;
      end
    endcase
  end

  // counter steps only in a dual-slope mode on a tick
  assign run = is_pc | is_pfc;
  assign step = run & tick;
  assign at_top = (st_r.cnt == top);
  assign at_floor = (st_r.cnt == dspt_pkg::COUNT_FLOOR);

  // per-channel field views
  assign com[0] = st_r.ctrl.com_a;
  assign com[1] = st_r.ctrl.com_b;
  assign dir_bits[0] = st_r.ctrl.dir_a;
  assign dir_bits[1] = st_r.ctrl.dir_b;

  //==========================================================
  // compare channels: match, next output level, pin enable
  for (genvar i = 0; i < 2; i++)
  begin : g_chan
    logic toggle_mode;
    logic inv;
    logic ext_lo;
    logic ext_hi;

    // a compare value above top never matches
    assign match[i] = run && (st_r.cnt == st_r.cmp[i])
      && (st_r.cmp[i] <= top);

    // toggle only for channel a with channel a as top
    assign toggle_mode = (i == 0) && cmpa_top_sel
      && (com[i] == dspt_pkg::COM_TOGGLE);
    assign inv = (com[i] == dspt_pkg::COM_INV);
    assign ext_lo = (st_r.cmp[i] == dspt_pkg::COUNT_FLOOR);
    assign ext_hi = (st_r.cmp[i] == top);

    // level chosen at each step
    always_comb
    begin
      if (toggle_mode)
      begin
        wave_nxt[i] = st_r.wave[i] ^ match[i];
      end
      else if (ext_lo)
      begin
        wave_nxt[i] = inv;
      end
      else if (ext_hi)
      begin
        wave_nxt[i] = ~inv;
      end
      else if (match[i])
      begin
        // up: clear (normal); down: set (normal)
        wave_nxt[i] = (st_r.dir == dspt_pkg::DSPT_DOWN) ^ inv;
      end
      else
      begin
        wave_nxt[i] = st_r.wave[i];
      end
    end

    // pwm codes connect either channel, toggle only channel a
    assign connected[i] = run && ((com[i] == dspt_pkg::COM_NONINV)
      || (com[i] == dspt_pkg::COM_INV) || toggle_mode);
  end

  //==========================================================
  // hardware flag events
  always_comb
  begin
    flag_set = 4'h0;
    flag_set[dspt_pkg::FLAG_OVF] = step & at_floor;
    flag_set[dspt_pkg::FLAG_CAP] = step & at_top & cap_top_sel;
    flag_set[dspt_pkg::FLAG_CMPA] = step & (match[0]
      | (at_top & cmpa_top_sel));
    flag_set[dspt_pkg::FLAG_CMPB] = step & match[1];
  end

  // software clear, write one to clear
  assign flag_clr = (bus.wr && bus.addr == dspt_pkg::ADDR_FLAGS)
    ? bus.wdata[3:0] : 4'h0;

  //==========================================================
  // next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rdata = 16'h0000;

    // sticky flags, a set beats a clear in the same cycle
    st_nxt.flags = (st_r.flags & ~flag_clr) | flag_set;

    // counter and direction
    if (step)
    begin
      case (st_r.dir)
        dspt_pkg::DSPT_UP:
        begin
          if (at_top)
          begin
            // top is held for one tick, then we turn
            st_nxt.dir = dspt_pkg::DSPT_DOWN;
            st_nxt.cnt = 16'(st_r.cnt - 16'h0001);
          end
          else
          begin
            st_nxt.cnt = 16'(st_r.cnt + 16'h0001);
          end
        end
        dspt_pkg::DSPT_DOWN:
        begin
          if (at_floor)
          begin
            st_nxt.dir = dspt_pkg::DSPT_UP;
            st_nxt.cnt = 16'(st_r.cnt + 16'h0001);
          end
          else
          begin
            st_nxt.cnt = 16'(st_r.cnt - 16'h0001);
          end
        end
        default:
        begin
          st_nxt.dir = dspt_pkg::DSPT_UP;
        end
      endcase
      st_nxt.wave = wave_nxt;
    end

    // buffered compare reload at the update point
    if (!run)
    begin
      st_nxt.cmp = st_r.cmp_buf;
    end
    else if (step && is_pc && at_top)
    begin
      st_nxt.cmp = st_r.cmp_buf;
    end
    else if (step && is_pfc && at_floor)
    begin
      st_nxt.cmp = st_r.cmp_buf;
    end

    // pins enabled only when direction bit selects output
    st_nxt.oe = connected & dir_bits;

    // register writes
    if (bus.wr)
    begin
      case (bus.addr)
        dspt_pkg::ADDR_CTRL:
        begin
          st_nxt.ctrl = dspt_pkg::dspt_ctrl_t'(bus.wdata);
          st_nxt.ctrl.rsvd = 3'h0;
        end
        dspt_pkg::ADDR_CMPA:
        begin
          st_nxt.cmp_buf[0] = bus.wdata & wmask;
        end
        dspt_pkg::ADDR_CMPB:
        begin
          st_nxt.cmp_buf[1] = bus.wdata & wmask;
        end
        dspt_pkg::ADDR_CAPTOP:
        begin
          st_nxt.cap_top = bus.wdata;
        end
        default:
        begin
          st_nxt.cap_top = st_r.cap_top;
        end
      endcase
    end

    // register reads, data valid one cycle later only
    if (bus.rd)
    begin
      case (bus.addr)
        dspt_pkg::ADDR_CTRL: st_nxt.rdata = 16'(st_r.ctrl);
        dspt_pkg::ADDR_CMPA: st_nxt.rdata = st_r.cmp_buf[0];
        dspt_pkg::ADDR_CMPB: st_nxt.rdata = st_r.cmp_buf[1];
        dspt_pkg::ADDR_CAPTOP: st_nxt.rdata = st_r.cap_top;
        dspt_pkg::ADDR_COUNT: st_nxt.rdata = st_r.cnt;
        dspt_pkg::ADDR_FLAGS: st_nxt.rdata = {12'h000, st_r.flags};
        default: st_nxt.rdata = 16'h0000;
      endcase
    end
  end

  //==========================================================
  // state register
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      st_r <= '0;
      st_r.ctrl <= dspt_pkg::dspt_ctrl_t'(dspt_pkg::CTRL_RESET);
      st_r.cap_top <= dspt_pkg::VALUE_RESET;
      st_r.cnt <= dspt_pkg::COUNT_FLOOR;
      st_r.dir <= dspt_pkg::DSPT_UP;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  //==========================================================
  // outputs straight from state
  assign RDATA = st_r.rdata;
  assign OC_A = st_r.wave[0];
  assign OC_B = st_r.wave[1];
  assign OC_A_OE = st_r.oe[0];
  assign OC_B_OE = st_r.oe[1];

endmodule // dspt_timer

// ### tb/dspt_timer_props.sv
// port checker for the dual-slope pwm timer
//=====
// checker
module dspt_timer_props (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  input wire logic OC_A,
  input wire logic OC_A_OE,
  input wire logic OC_B,
  input wire logic OC_B_OE
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ctrl_r, cmpa_r, cap_r, mask;
  logic run, oe_a, oe_b;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  // mode decode, write mask, expected enables
  always_comb
  begin
    run = ctrl_r[3:0] inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb};
    case (ctrl_r[3:0])
      dspt_pkg::WM_PC_8: mask = dspt_pkg::TOP_8BIT;
      dspt_pkg::WM_PC_9: mask = dspt_pkg::TOP_9BIT;
      dspt_pkg::WM_PC_10: mask = dspt_pkg::TOP_10BIT;
      default: mask = 16'hffff;
    endcase
    oe_a = run && ctrl_r[11] && (ctrl_r[5] || (ctrl_r[4] && ctrl_r[3:0] inside {4'h9, 4'hb}));
    oe_b = run && ctrl_r[12] && ctrl_r[7];
  end
  // shadow of software writes
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      ctrl_r <= 16'h0000;
      cmpa_r <= 16'h0000;
      cap_r <= 16'h0000;
    end
    else if (WR && ADDR == dspt_pkg::ADDR_CTRL)
      ctrl_r <= WDATA & 16'h1fff;
    else if (WR && ADDR == dspt_pkg::ADDR_CMPA)
      cmpa_r <= WDATA & mask;
    else if (WR && ADDR == dspt_pkg::ADDR_CAPTOP)
      cap_r <= WDATA;
  end
  sequence s_cfg_held;
    $stable(ctrl_r) ##1 $stable(ctrl_r);
  endsequence
  sequence s_stopped;
    !run ##1 !run;
  endsequence
  a_rdata_idle: assert property (!RD |=> RDATA == 16'h0000)
    else $error("read data not zero outside a read");
  a_ctrl_read: assert property (RD && ADDR == dspt_pkg::ADDR_CTRL |=> RDATA == $past(ctrl_r))
    else $error("control readback wrong");
  a_cmpa_read:
    assert property (RD && ADDR == dspt_pkg::ADDR_CMPA |=> RDATA == $past(cmpa_r))
    else $error("compare a readback wrong");
  a_cap_read:
    assert property (RD && ADDR == dspt_pkg::ADDR_CAPTOP |=> RDATA == $past(cap_r))
    else $error("capture top readback wrong");
  a_unmapped_read: assert property (RD && ADDR > dspt_pkg::ADDR_FLAGS |=> RDATA == 16'h0000)
    else $error("unmapped read not zero");
  a_count_bound:
    assert property (RD && ADDR == dspt_pkg::ADDR_COUNT && ctrl_r[3:0] inside {4'h8, 4'ha}
      |=> RDATA <= $past(cap_r))
    else $error("count above capture top");
  a_oe_a_cfg: assert property (s_cfg_held |-> OC_A_OE == oe_a)
    else $error("pin a enable wrong");
  a_oe_b_cfg: assert property (s_cfg_held |-> OC_B_OE == oe_b)
    else $error("pin b enable wrong");
  a_stop_frozen: assert property (s_stopped |-> $stable(OC_A) && $stable(OC_B))
    else $error("outputs moved while stopped");
  a_reset_clear: assert property ($fell(SRST) |-> RDATA == 16'h0000 && !OC_A && !OC_B
    && !OC_A_OE && !OC_B_OE)
    else $error("outputs not clear after reset");
endmodule // dspt_timer_props

bind dspt_timer dspt_timer_props u_props (.CLK_SYS, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA,
  .OC_A, .OC_A_OE, .OC_B, .OC_B_OE);

// ### tb/testbench.sv
// self-checking bench for the dual-slope pwm timer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0] wave;
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [15:0] cmpa;
    logic [15:0] cmpb;
    logic [15:0] cap;
    logic [15:0] hi_a;
    logic [15:0] hi_b;
    logic [3:0] flags;
  } dspt_row_t;
  logic CLK_SYS = 1'b0;
  logic SRST = 1'b1;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000;
  logic [15:0] RDATA, d, mx;
  logic [15:0] cnt [14];
  logic OC_A, OC_A_OE, OC_B, OC_B_OE;
  int n_mismatch = 0;
  int checks = 0;
  int divs [4] = '{8, 64, 256, 1024};
  logic [15:0] tops [3] = '{dspt_pkg::TOP_8BIT, dspt_pkg::TOP_9BIT, dspt_pkg::TOP_10BIT};
  // mode, polarities, compares, top, high cycles per 60, flags
  dspt_row_t rows [4] = '{
    '{4'h8, 2'h2, 2'h3, 16'h0002, 16'h0000, 16'h0005, 16'h0018, 16'h003c, 4'hf},
    '{4'ha, 2'h3, 2'h2, 16'h0002, 16'h0005, 16'h0005, 16'h0024, 16'h003c, 4'hf},
    '{4'hb, 2'h1, 2'h2, 16'h0003, 16'h0001, 16'h0000, 16'h001e, 16'h0014, 4'hd},
    '{4'h9, 2'h1, 2'h2, 16'h0003, 16'h0004, 16'h0000, 16'h001e, 16'h0000, 4'h5}};

  //=====
  // clock and design
  always #2 CLK_SYS = ~CLK_SYS;
  dspt_timer DUT (.CLK_SYS, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .OC_A, .OC_A_OE,
    .OC_B, .OC_B_OE);

  //=====
  // tasks
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] dat);
    @(posedge CLK_SYS);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= dat;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] exp, string name);
    @(posedge CLK_SYS);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    @(negedge CLK_SYS);
    chk(name, RDATA, exp);
  endtask
  task automatic rst();
    @(posedge CLK_SYS);
    SRST <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    SRST <= 1'b0;
  endtask
  task automatic run_row(int i, logic [2:0] ps, int n);
    int ha;
    int hb;
    ha = 0;
    hb = 0;
    rst();
    wr(dspt_pkg::ADDR_CAPTOP, rows[i].cap);
    wr(dspt_pkg::ADDR_CMPA, rows[i].cmpa);
    wr(dspt_pkg::ADDR_CMPB, rows[i].cmpb);
    wr(dspt_pkg::ADDR_CTRL, {5'h03, ps, rows[i].com_b, rows[i].com_a, rows[i].wave});
    repeat (n / 2) @(negedge CLK_SYS);
    repeat (n)
    begin
      @(negedge CLK_SYS);
      ha += int'(OC_A === 1'b1);
      hb += int'(OC_B === 1'b1);
    end
    chk("oe", {14'h0000, OC_B_OE, OC_A_OE}, 16'h0003);
    chk("oc_a", 16'(ha), 16'(rows[i].hi_a * n / 60));
    chk("oc_b", 16'(hb), 16'(rows[i].hi_b * n / 60));
    rd(dspt_pkg::ADDR_FLAGS, {12'h000, rows[i].flags}, "flags");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  //=====
  // watchdog
  initial
  begin
    #300us;
    n_mismatch++;
    conclude();
  end

  //=====
  // main sequence
  initial
  begin
    repeat (10) @(posedge CLK_SYS);
    SRST <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      run_row(i, 3'h1, 60);
      $display("row %0d done", i);
    end
    // sticky flags, cleared bit by bit
    wr(dspt_pkg::ADDR_CTRL, 16'h0000);
    wr(dspt_pkg::ADDR_FLAGS, 16'h0001);
    rd(dspt_pkg::ADDR_FLAGS, 16'h0004, "flags_w1c");
    wr(dspt_pkg::ADDR_FLAGS, 16'h0004);
    rd(dspt_pkg::ADDR_FLAGS, 16'h0000, "flags_clr");
    $display("flag clear done");
    // reset values, reserved bits, read-only count, unmapped index
    rst();
    chk("pins", {12'h000, OC_A, OC_A_OE, OC_B, OC_B_OE}, 16'h0000);
    rd(dspt_pkg::ADDR_COUNT, 16'h0000, "count_rst");
    rd(dspt_pkg::ADDR_CMPA, 16'h0000, "cmpa_rst");
    wr(dspt_pkg::ADDR_CTRL, 16'hffff);
    rd(dspt_pkg::ADDR_CTRL, 16'h1fff, "ctrl");
    wr(dspt_pkg::ADDR_COUNT, 16'h1234);
    rd(dspt_pkg::ADDR_COUNT, 16'h0000, "count_ro");
    rd(4'h9, 16'h0000, "unmapped");
    wr(dspt_pkg::ADDR_CAPTOP, 16'hbeef);
    rd(dspt_pkg::ADDR_CAPTOP, 16'hbeef, "captop");
    for (int k = 0; k < 3; k++)
    begin
      wr(dspt_pkg::ADDR_CTRL, 16'(k + 1));
      wr(dspt_pkg::ADDR_CMPB, 16'hffff);
      rd(dspt_pkg::ADDR_CMPB, tops[k], "cmpb_mask");
    end
    $display("register tests done");
    // count walk read every cycle
    rst();
    wr(dspt_pkg::ADDR_CAPTOP, 16'h0005);
    wr(dspt_pkg::ADDR_CTRL, 16'h0108);
    @(posedge CLK_SYS);
    RD <= 1'b1;
    ADDR <= dspt_pkg::ADDR_COUNT;
    @(posedge CLK_SYS);
    for (int k = 0; k < 14; k++)
    begin
      @(negedge CLK_SYS);
      cnt[k] = RDATA;
    end
    @(posedge CLK_SYS);
    RD <= 1'b0;
    mx = 16'h0000;
    for (int k = 1; k < 14; k++)
    begin
      d = cnt[k] - cnt[k - 1];
      chk("count_step", {15'h0000, d === 16'h0001 || d === 16'hffff}, 16'h0001);
      if (cnt[k] > mx)
        mx = cnt[k];
    end
    chk("count_top", mx, 16'h0005);
    $display("count walk done");
    // toggle row through the slower prescales
    for (int p = 0; p < 4; p++)
      run_row(2, 3'(p + 2), 12 * divs[p]);
    $display("prescale done");
    conclude();
  end
endmodule // testbench
